// ===== hdl/isa_xbus_ctrl.v
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "isa_xbus_consts.vh"
module isa_xbus_ctrl #(
    parameter RST_CYCLES = `RST_PULSE_CYC
) (
    input  wire        clock_i,
    input  wire        reset_i,
    input  wire        enable_i,
    input  wire [1:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    input  wire        power_good_i,
    input  wire        mode_strap_i,
    input  wire        xbus_read_n_i,
    input  wire        xbus_buffer_en_n_i,
    input  wire [7:0]  break_event_i,
    input  wire        cyc_start_i,
    input  wire        cyc_dma_i,
    input  wire        cyc_isa_master_i,
    input  wire        cyc_xbus_i,
    input  wire        cyc_xbus_read_i,
    input  wire        cyc_rom_i,
    input  wire        cyc_io_i,
    input  wire [15:0] cyc_addr_i,
    input  wire [3:0]  cyc_cmd_i,
    input  wire [2:0]  dma_grant_chan_i,
    input  wire        dma_grant_i,
    input  wire        dma_count_zero_i,
    input  wire [6:0]  dma_request_i,
    input  wire        channel_ready_i,
    input  wire        zero_wait_n_i,
    output reg         cyc_done_o,
    output reg         addr_latch_en_o,
    output reg         addr_enable_o,
    output reg         terminal_count_o,
    output reg  [2:0]  dma_ack_code_o,
    output reg  [3:0]  cmd_n_o,
    output reg         cmd_oe_o,
    output reg         dual_pin_o,
    output reg         xbus_read_n_o,
    output reg         xbus_read_n_oe_o,
    output reg         xbus_buffer_en_n_o,
    output reg         xbus_buffer_en_n_oe_o,
    output reg         xbus_select_lo_o,
    output reg         xbus_select_hi_o,
    output wire [6:0]  dma_request_o
);

    // ****************************************
    // State
    // ****************************************
    localparam ST_IDLE  = 2'd0;
    localparam ST_ADDR  = 2'd1;
    localparam ST_CMD   = 2'd2;
    localparam ST_END   = 2'd3;

    reg [1:0]  state_q;
    reg [2:0]  rdy_cnt_q;
    reg        dma_q;
    reg        xrd_q;
    reg        xbuf_q;
    reg        strap_done_q;
    reg        mode_alt_q;
    reg        test_mode_q;
    reg        xrd_strap_q;
    reg [7:0]  ctrl_q;
    reg [7:0]  break_en_q;
    reg        pg_q;
    reg [31:0] rst_cnt_q;
    reg        bus_rst_q;
    reg        pm_act_q;
    reg        rd_ack_q;
    wire       trigger;
    wire       pg_rise;
    wire       hot_rst_req;
    wire       drv_rst_req;
    wire       io_800_hit;

    assign dma_request_o   = dma_request_i;
    // Read waits one cycle so its data stands when taken
    assign avs_waitrequest = avs_read && !rd_ack_q;

    assign io_800_hit = cyc_io_i && (cyc_addr_i[15:8] == `IO_800_BASE);

    assign pg_rise     = power_good_i && !pg_q;
    assign hot_rst_req = ctrl_q[`CTRL_HOT_RESET];
    assign drv_rst_req = ctrl_q[`CTRL_RST_DRIVE];
    assign trigger     = pg_rise || hot_rst_req || drv_rst_req;

    // ****************************************
    // Functions
    // ****************************************
    // Channel code or idle code
    function [2:0] ack_code;
        input       granted;
        input [2:0] chan;
        begin
            ack_code = granted ? chan : `DMA_ACK_IDLE;
        end
    endfunction

    function sel_pin;
        input alt;
        input alt_hit;
        input addr_bit;
        begin
            sel_pin = alt ? alt_hit : addr_bit;
        end
    endfunction

    // ****************************************
    // Read wait state
    // ****************************************
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            rd_ack_q <= 1'b0;
        end else if (enable_i) begin
            rd_ack_q <= avs_read && !rd_ack_q;
        end
    end

    // ****************************************
    // Register bus
    // ****************************************
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl_q       <= 8'h00;
            break_en_q   <= 8'h00;
            avs_readdata <= 32'h0000_0000;
        end else if (enable_i) begin
            if (avs_write && avs_address == `REG_CTRL) begin
                ctrl_q <= avs_writedata[7:0];
            end else begin
                // Self-clearing hot-reset trigger bit; the reset-drive bit holds its value
                ctrl_q[`CTRL_HOT_RESET] <= 1'b0;
            end
            if (avs_write && avs_address == `REG_BREAK) begin
                break_en_q <= avs_writedata[7:0];
            end
            if (avs_read && !rd_ack_q) begin
                case (avs_address)
                    `REG_CTRL: begin
                        avs_readdata <= {24'h00_0000, ctrl_q[7:3],
                                         xrd_strap_q && mode_alt_q, ctrl_q[1:0]};
                    end
                    `REG_STATUS: begin
                        avs_readdata <= {27'h000_0000, pm_act_q, bus_rst_q,
                                         xrd_strap_q, test_mode_q, mode_alt_q};
                    end
                    `REG_DMA: begin
                        avs_readdata <= {25'h000_0000, dma_request_i};
                    end
                    `REG_BREAK: begin
                        avs_readdata <= {24'h00_0000, break_en_q};
                    end
                    default: begin
                        avs_readdata <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Straps
    // ****************************************
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            strap_done_q <= 1'b0;
            mode_alt_q   <= 1'b0;
            test_mode_q  <= 1'b0;
            xrd_strap_q  <= 1'b0;
        end else if (enable_i && !strap_done_q) begin
            strap_done_q <= 1'b1;
            mode_alt_q   <= mode_strap_i;
            test_mode_q  <= !xbus_buffer_en_n_i;
            xrd_strap_q  <= xbus_read_n_i;
        end
    end

    // ****************************************
    // Reset pulse and activity
    // ****************************************
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            pg_q      <= 1'b0;
            rst_cnt_q <= 32'h0000_0000;
            bus_rst_q <= 1'b1;
            pm_act_q  <= 1'b0;
        end else if (enable_i) begin
            pg_q <= power_good_i;
            if (trigger) begin
                rst_cnt_q <= RST_CYCLES;
                bus_rst_q <= 1'b1;
            end else if (rst_cnt_q != 32'h0000_0000) begin
                rst_cnt_q <= rst_cnt_q - 32'h0000_0001;
                bus_rst_q <= (rst_cnt_q != 32'h0000_0001);
            end else begin
                bus_rst_q <= 1'b0;
            end
            pm_act_q <= |(break_event_i & break_en_q);
        end
    end

    // ****************************************
    // Bus cycle
    // ****************************************
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            state_q          <= ST_IDLE;
            rdy_cnt_q        <= 3'h0;
            dma_q            <= 1'b0;
            xrd_q            <= 1'b0;
            xbuf_q           <= 1'b0;
            cyc_done_o       <= 1'b0;
            addr_latch_en_o  <= 1'b0;
            addr_enable_o    <= 1'b0;
            terminal_count_o <= 1'b0;
            dma_ack_code_o   <= `DMA_ACK_IDLE;
            cmd_n_o          <= 4'hF;
            cmd_oe_o         <= 1'b0;
            xbus_select_lo_o <= 1'b0;
            xbus_select_hi_o <= 1'b0;
        end else if (enable_i) begin
            cyc_done_o      <= 1'b0;
            addr_latch_en_o <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (cyc_start_i) begin
                        state_q <= ST_ADDR;
                        dma_q   <= cyc_dma_i;
                        xrd_q   <= cyc_xbus_i && cyc_xbus_read_i;
                        xbuf_q  <= cyc_xbus_i;
                        addr_latch_en_o <= 1'b1;
                        addr_enable_o   <= cyc_dma_i;
                        dma_ack_code_o  <= ack_code(cyc_dma_i && dma_grant_i, dma_grant_chan_i);
                        cmd_oe_o <= !cyc_isa_master_i;
                        xbus_select_lo_o <= sel_pin(mode_alt_q, cyc_rom_i, cyc_addr_i[0]);
                        xbus_select_hi_o <= sel_pin(mode_alt_q, io_800_hit, cyc_addr_i[1]);
                    end
                end
                ST_ADDR: begin
                    state_q   <= ST_CMD;
                    rdy_cnt_q <= `READY_CYC;
                    if (cmd_oe_o) begin
                        cmd_n_o <= ~cyc_cmd_i;
                    end else begin
                        cmd_n_o <= 4'hF;
                    end
                    terminal_count_o <= dma_q && dma_count_zero_i;
                end
                ST_CMD: begin
                    if (rdy_cnt_q != 3'h0) begin
                        rdy_cnt_q <= rdy_cnt_q - 3'h1;
                    end
                    if (!zero_wait_n_i) begin
                        state_q <= ST_END;
                    end else if (rdy_cnt_q == 3'h0 && channel_ready_i) begin
                        state_q <= ST_END;
                    end
                end
                ST_END: begin
                    state_q          <= ST_IDLE;
                    cyc_done_o       <= 1'b1;
                    cmd_n_o          <= 4'hF;
                    cmd_oe_o         <= 1'b0;
                    addr_enable_o    <= 1'b0;
                    terminal_count_o <= 1'b0;
                    dma_ack_code_o   <= ack_code(1'b0, 3'h0);
                    xbus_select_lo_o <= 1'b0;
                    xbus_select_hi_o <= 1'b0;
                    xrd_q            <= 1'b0;
                    xbuf_q           <= 1'b0;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // Pin outputs
    // ****************************************
    always @* begin
        if (mode_alt_q) begin
            dual_pin_o = bus_rst_q || reset_i;
        end else begin
            dual_pin_o = !pm_act_q;
        end
    end

    always @* begin
        xbus_read_n_o    = !(xrd_q && state_q == ST_CMD);
        xbus_read_n_oe_o = strap_done_q;
    end

    always @* begin
        xbus_buffer_en_n_o    = !(xbuf_q && state_q != ST_IDLE);
        xbus_buffer_en_n_oe_o = strap_done_q;
    end

endmodule // isa_xbus_ctrl

// ===== include/isa_xbus_consts.vh
`ifndef ISA_XBUS_CONSTS_VH
`define ISA_XBUS_CONSTS_VH
// Register word addresses (Avalon word index)
`define REG_CTRL        2'h0
`define REG_STATUS      2'h1
`define REG_DMA         2'h2
`define REG_BREAK       2'h3
// Control register fields
`define CTRL_HOT_RESET  0
`define CTRL_RST_DRIVE  3
// Status register fields
`define STAT_MODE_ALT   0
`define STAT_TEST_MODE  1
`define STAT_XRD_STRAP  2
`define STAT_BUS_RST    3
`define STAT_PM_ACT     4
// Encoded acknowledge idle code
`define DMA_ACK_IDLE    3'h4
// I/O select window, upper address bits
`define IO_800_BASE     8'h08
// Reset pulse time
`define RST_PULSE_US    1000
`define CLK_MHZ         50
`define RST_PULSE_CYC   (`RST_PULSE_US * `CLK_MHZ)
`define READY_CYC       3'h4
`endif

// ===== verif/isa_xbus_ctrl_props.sv
`timescale 1ns/1ps
// ****************************************
// Port checker
// ****************************************
module isa_xbus_ctrl_props #(
    parameter RST_CYCLES = 20
) (
    input wire logic        clock_i,
    input wire logic        reset_i,
    input wire logic        mode_strap_i,
    input wire logic        power_good_i,
    input wire logic        cyc_start_i,
    input wire logic        cyc_isa_master_i,
    input wire logic        cyc_xbus_i,
    input wire logic        cyc_io_i,
    input wire logic [15:0] cyc_addr_i,
    input wire logic [6:0]  dma_request_i,
    input wire logic [6:0]  dma_request_o,
    input wire logic        addr_latch_en_o,
    input wire logic        addr_enable_o,
    input wire logic        terminal_count_o,
    input wire logic [2:0]  dma_ack_code_o,
    input wire logic        cmd_oe_o,
    input wire logic        dual_pin_o,
    input wire logic        xbus_read_n_o,
    input wire logic        xbus_read_n_oe_o,
    input wire logic        xbus_buffer_en_n_o,
    input wire logic        xbus_select_hi_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    property p_req_echo; dma_request_o == dma_request_i; endproperty
    a_req_echo: assert property (p_req_echo) else $error("request echo wrong");
    property p_ale_cause; $rose(addr_latch_en_o) |-> $past(cyc_start_i); endproperty
    a_ale_cause: assert property (p_ale_cause) else $error("latch pulse uncaused");
    property p_ack_aen; dma_ack_code_o != 3'h4 |-> addr_enable_o; endproperty
    a_ack_aen: assert property (p_ack_aen) else $error("ack code outside dma");
    property p_tc_dma; terminal_count_o |-> addr_enable_o; endproperty
    a_tc_dma: assert property (p_tc_dma) else $error("count end outside dma");
    property p_master_float; cyc_start_i && cyc_isa_master_i |=> !cmd_oe_o [*3]; endproperty
    a_master_float: assert property (p_master_float) else $error("commands driven");
    property p_rst_pulse; $rose(power_good_i) && mode_strap_i |-> ##2 dual_pin_o [*8]; endproperty
    a_rst_pulse: assert property (p_rst_pulse) else $error("bus reset short");
    property p_buf_en; cyc_start_i && cyc_xbus_i |-> ##[1:3] !xbus_buffer_en_n_o; endproperty
    a_buf_en: assert property (p_buf_en) else $error("buffer not enabled");
    property p_rd_dir; xbus_read_n_oe_o && !xbus_read_n_o |-> !xbus_buffer_en_n_o; endproperty
    a_rd_dir: assert property (p_rd_dir) else $error("read without buffer");
    property p_io_sel;
        cyc_start_i && cyc_io_i && mode_strap_i && cyc_addr_i[15:8] == 8'h08
            |-> ##[1:2] xbus_select_hi_o;
    endproperty
    a_io_sel: assert property (p_io_sel) else $error("io select missing");
endmodule // isa_xbus_ctrl_props
bind isa_xbus_ctrl isa_xbus_ctrl_props #(.RST_CYCLES(RST_CYCLES)) u_props (.*);

// ===== verif/isa_slave_model.sv
`timescale 1ns/1ps
// ****************************************
// Slave card model
// ****************************************
module isa_slave_model (
    input  wire logic       clock_i,
    input  wire logic [3:0] cmd_n_i,
    input  wire logic [3:0] wait_i,
    input  wire logic       fast_i,
    output logic            channel_ready_o,
    output logic            zero_wait_n_o
);
    logic [3:0] cnt_q = 4'h0;
    always @(posedge clock_i) begin
        if (&cmd_n_i)
            cnt_q <= wait_i;
        else if (cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
    end
    assign channel_ready_o = (&cmd_n_i) || (cnt_q == 4'h0);
    assign zero_wait_n_o = !(fast_i && !(&cmd_n_i));
endmodule // isa_slave_model

// ===== verif/test_isa_xbus_side_signalling.sv
`timescale 1ns/1ps
// ****************************************
// Testbench
// ****************************************
module test_isa_xbus_side_signalling;
    localparam RC = 20;
    logic clock_i = 0, reset_i = 1, enable_i = 1, cyc_rom_i = 0, power_good_i = 0;
    logic mode_strap_i = 1, avs_read = 0, avs_write = 0, s_rd = 1, s_buf = 1, fast = 0;
    logic cyc_start_i = 0, cyc_dma_i = 0, cyc_isa_master_i = 0, cyc_xbus_i = 0;
    logic cyc_xbus_read_i = 0, cyc_io_i = 0, dma_grant_i = 0, dma_count_zero_i = 0;
    logic [1:0] avs_address = 0;
    logic [31:0] avs_writedata = 0, rd = 0, w;
    logic [15:0] cyc_addr_i = 0;
    logic [7:0] break_event_i = 0;
    logic [3:0] cyc_cmd_i = 0, wait_n = 0;
    logic [2:0] dma_grant_chan_i = 0, ch;
    logic [6:0] dma_request_i = 0, snap;
    logic [5:0] sel;
    int seed = 32'h7531, miscompares = 0, checks = 0, n, len0;
    wire [31:0] avs_readdata;
    wire [6:0] dma_request_o;
    wire [3:0] cmd_n_o;
    wire [2:0] dma_ack_code_o;
    wire avs_waitrequest, cyc_done_o, addr_latch_en_o, addr_enable_o, terminal_count_o;
    wire cmd_oe_o, dual_pin_o, xbus_read_n_o, xbus_read_n_oe_o, xbus_buffer_en_n_o;
    wire xbus_buffer_en_n_oe_o, xbus_select_lo_o, xbus_select_hi_o, channel_ready_i;
    wire zero_wait_n_i;
    wire rd_pin = xbus_read_n_oe_o ? xbus_read_n_o : s_rd;
    wire buf_pin = xbus_buffer_en_n_oe_o ? xbus_buffer_en_n_o : s_buf;
    always #10 clock_i = !clock_i;
    isa_xbus_ctrl #(.RST_CYCLES(RC)) uut (.xbus_read_n_i(rd_pin), .xbus_buffer_en_n_i(buf_pin), .*);
    isa_slave_model sm (.clock_i(clock_i), .cmd_n_i(cmd_n_o), .wait_i(wait_n), .fast_i(fast),
        .channel_ready_o(channel_ready_i), .zero_wait_n_o(zero_wait_n_i));
    task chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch at %0t: seen %h, expected %h", $time, s, e);
        end
    endtask
    task test_done;
        if (miscompares == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task look(input int k);
        repeat (k) @(posedge clock_i);
        @(negedge clock_i);
    endtask
    task rst(input logic m, input logic b);
        @(posedge clock_i);
        mode_strap_i <= m;
        s_buf <= b;
        reset_i <= 1;
        repeat (10) @(posedge clock_i);
        reset_i <= 0;
        repeat (2) @(posedge clock_i);
    endtask
    task bus(input logic wr, input logic [1:0] a, input logic [31:0] d);
        @(posedge clock_i);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        if (n >= 50) begin
            miscompares++;
            test_done;
        end
        avs_write <= 0;
        avs_read <= 0;
    endtask
    task cyc(input logic [5:0] q, input logic [15:0] a);
        @(posedge clock_i);
        {cyc_dma_i, cyc_isa_master_i, cyc_xbus_i, cyc_xbus_read_i, cyc_io_i} <= q[5:1];
        dma_count_zero_i <= q[0];
        dma_grant_i <= q[5];
        cyc_addr_i <= a;
        cyc_cmd_i <= q[1] ? 4'h8 : 4'h1;
        dma_request_i <= $random(seed);
        cyc_start_i <= 1;
        @(posedge clock_i);
        cyc_start_i <= 0;
        n = 0;
        do begin
            @(negedge clock_i);
            n++;
            if (n == 2) begin
                snap = {xbus_buffer_en_n_o, xbus_read_n_o, terminal_count_o, addr_enable_o,
                        dma_ack_code_o};
                sel = {xbus_select_hi_o, xbus_select_lo_o, cmd_n_o};
            end
        end while (cyc_done_o !== 1'b1 && n < 100);
        if (n >= 100) begin
            miscompares++;
            test_done;
        end
        @(posedge clock_i);
        dma_grant_i <= 0;
    endtask
    initial begin
        s_rd = $random(seed);
        look(3);
        chk(dual_pin_o, 1);
        rst(1, 1);
        bus(0, 2'h1, 0);
        chk(rd & 32'h7, {29'h0, s_rd, 2'h1});
        bus(0, 2'h0, 0);
        chk(rd[2], s_rd);
        power_good_i <= 1;
        look(5);
        chk(dual_pin_o, 1);
        look(RC + 5);
        chk(dual_pin_o, 0);
        bus(1, 2'h0, 1);
        look(10);
        bus(1, 2'h0, 1);
        look(RC - 8);
        chk(dual_pin_o, 1);
        look(RC + 5);
        chk(dual_pin_o, 0);
        bus(1, 2'h0, 8);
        look(RC + 5);
        chk(dual_pin_o, 1);
        bus(1, 2'h0, 0);
        look(RC + 5);
        chk(dual_pin_o, 0);
        cyc(6'h02, 16'h0300);
        len0 = n;
        repeat (3) begin
            w = $random(seed);
            wait_n <= {1'b0, w[2:0]} + 4'h5;
            cyc(6'h02, {w[3] ? 8'h08 : 8'h03, w[15:8]});
            chk(n >= wait_n + 3, 1);
        end
        wait_n <= 0;
        fast <= 1;
        cyc(6'h02, 16'h0300);
        chk(n < len0, 1);
        fast <= 0;
        cyc_rom_i <= 1;
        cyc(6'h00, 16'h0000);
        chk(sel, {2'b01, 4'hE});
        cyc_rom_i <= 0;
        for (int i = 0; i < 7; i++) begin
            ch = (i < 4) ? i : i + 1;
            dma_grant_chan_i <= ch;
            cyc(6'h20 | (i == 6), 16'h0000);
            chk(snap, {2'h3, i == 6, 1'b1, ch});
            look(1);
            chk(dma_ack_code_o, 3'h4);
        end
        cyc(6'h10, 16'h0000);
        chk(sel, 6'h0F);
        cyc(6'h0C, 16'h0060);
        chk(snap[6:5], 2'h0);
        rst(0, 1);
        cyc(6'h02, 16'h0002);
        chk(sel, {2'b10, 4'h7});
        w = $random(seed);
        bus(1, 2'h3, 32'h1 << w[2:0]);
        break_event_i <= 8'h1 << (w[2:0] + 3'h1);
        look(5);
        chk(dual_pin_o, 1);
        break_event_i <= 8'h1 << w[2:0];
        n = 0;
        while (dual_pin_o !== 1'b0 && n < 10) begin
            @(negedge clock_i);
            n++;
        end
        chk(dual_pin_o, 0);
        rst(0, 0);
        bus(0, 2'h1, 0);
        chk(rd & 32'h3, 32'h2);
        test_done;
    end
endmodule // test_isa_xbus_side_signalling
